// ### design/aia_ctrl.sv
// Purpose: Interrupt flags, masks and IF AGC / front-end controls of the audio decoder
// Assumes: Event and AGC error inputs are synchronous to clk_sys
// Notes:   Read data appear the cycle after the read strobe and only then

`timescale 1ns/1ps
`default_nettype none

module aia_ctrl (
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  input  wire aia_pkg::aia_bus_req_type     bus_req,
  output var  logic [aia_pkg::DATA_W-1:0]   bus_rdata,
  input  wire aia_pkg::aia_event_type       event_in,
  input  wire aia_pkg::aia_agc_sample_type  agc_sample,
  output var  logic [aia_pkg::GAIN_W-1:0]   vga_gain,
  output var  logic                         front_end_boost_enable,
  output var  logic                         decimation_source_select,
  output var  logic                         irq
);
  import aia_pkg::*;

  logic [DATA_W-1:0]       flags;
  logic [DATA_W-1:0]       next_flags;
  logic [DATA_W-1:0]       mask;
  logic [GAIN_W-1:0]       agc_hysteresis_a;
  logic [GAIN_W-1:0]       agc_hysteresis_b;
  logic [GAIN_W-1:0]       agc_error_threshold;
  logic [GAIN_W-1:0]       agc_bypass_value;
  logic                    agc_feedback_gain_enable;
  logic                    agc_bypass_enable;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] next_acc;
  logic [ERR_W-1:0]        err_mag;
  logic                    loop_step;
  logic                    step_down;
  logic                    step_up;

  function automatic logic wr_hit(input aia_bus_req_type req, input logic [ADDR_W-1:0] a);
    wr_hit = req.wr && (req.addr == a);
  endfunction

  function automatic logic [ERR_W-1:0] magnitude(input logic [ERR_W-1:0] v);
    magnitude = v[ERR_W-1] ? ERR_W'(-v) : v;
  endfunction

  // Event set wins over a same-cycle write-one clear
  always_comb begin
    next_flags = flags;
    if (wr_hit(bus_req, REG_STATUS_ADDR)) begin
      next_flags = flags & ~bus_req.wdata;
    end
    next_flags = next_flags | DATA_W'(event_in);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags <= RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask <= RST_MASK;
    end else if (wr_hit(bus_req, REG_MASK_ADDR)) begin
      mask <= bus_req.wdata;
    end
  end

  // Registered so the pin is glitch free; lags the flags by one cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & ~mask);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      agc_hysteresis_a         <= RST_HYST_A;
      agc_hysteresis_b         <= RST_HYST_B;
      agc_error_threshold      <= RST_ERR_THR;
      agc_feedback_gain_enable <= 1'b0;
      agc_bypass_enable        <= 1'b0;
      agc_bypass_value         <= RST_BYPASS_VAL;
      front_end_boost_enable   <= 1'b0;
      decimation_source_select <= 1'b0;
    end else begin
      if (wr_hit(bus_req, REG_HYST_A_ADDR)) begin
        agc_hysteresis_a <= bus_req.wdata[GAIN_W-1:0];
      end
      if (wr_hit(bus_req, REG_HYST_B_ADDR)) begin
        agc_hysteresis_b <= bus_req.wdata[GAIN_W-1:0];
      end
      if (wr_hit(bus_req, REG_AGC_ADDR)) begin
        agc_error_threshold      <= bus_req.wdata[GAIN_W-1:0];
        agc_feedback_gain_enable <= bus_req.wdata[FLD_FB_GAIN_EN];
      end
      if (wr_hit(bus_req, REG_AFE_ADDR)) begin
        front_end_boost_enable <= bus_req.wdata[FLD_BOOST_EN];
        agc_bypass_enable      <= bus_req.wdata[FLD_BYPASS_EN];
        agc_bypass_value       <= bus_req.wdata[GAIN_W-1:0];
      end
      if (wr_hit(bus_req, REG_DEC_ADDR)) begin
        decimation_source_select <= bus_req.wdata[FLD_DEC_SEL];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= '0;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        REG_MASK_ADDR:   bus_rdata <= mask;
        REG_STATUS_ADDR: bus_rdata <= flags;
        REG_HYST_A_ADDR: bus_rdata <= {2'b00, agc_hysteresis_a};
        REG_HYST_B_ADDR: bus_rdata <= {2'b00, agc_hysteresis_b};
        REG_AGC_ADDR:    bus_rdata <= {1'b0, agc_feedback_gain_enable, agc_error_threshold};
        REG_AFE_ADDR:    bus_rdata <= {front_end_boost_enable, agc_bypass_enable, agc_bypass_value};
        REG_DEC_ADDR:    bus_rdata <= {7'h00, decimation_source_select};
        default:         bus_rdata <= '0;
      endcase
    end else begin
      bus_rdata <= '0;
    end
  end

  // Error above the threshold is integrated; the gain steps only once the
  // integral leaves the hysteresis band, which keeps the amplifier from dithering
  always_comb begin
    err_mag   = magnitude(agc_sample.err);
    loop_step = agc_sample.valid && agc_feedback_gain_enable
                && (err_mag > ERR_W'(agc_error_threshold));
    next_acc  = acc + ACC_W'(signed'(agc_sample.err));
    step_down = next_acc > $signed({3'b000, agc_hysteresis_b});
    step_up   = next_acc < -$signed({3'b000, agc_hysteresis_a});
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vga_gain <= RST_VGA_GAIN;
      acc      <= '0;
    end else if (agc_bypass_enable) begin
      vga_gain <= agc_bypass_value;
      acc      <= '0;
    end else if (loop_step) begin
      if (step_down) begin
        acc <= '0;
        if (vga_gain != GAIN_MIN) begin
          vga_gain <= vga_gain - 6'h01;
        end
      end else if (step_up) begin
        acc <= '0;
        if (vga_gain != GAIN_MAX) begin
          vga_gain <= vga_gain + 6'h01;
        end
      end else begin
        acc <= next_acc;
      end
    end
  end

  AST_FLAG7_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      event_in.radio_data_ready_flag |=> flags[7])
    else $error("radio data flag not set");

  AST_FLAG6_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      event_in.high_bit_error_flag |=> flags[6])
    else $error("bit error flag not set");

  AST_FLAG5_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      event_in.digital_sound_lock_lost_flag |=> flags[5])
    else $error("lock lost flag not set");

  AST_FLAG4_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      event_in.if_signal_lost_flag |=> flags[4])
    else $error("IF loss flag not set");

  AST_FLAG3_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      event_in.format_detect_done_flag |=> flags[3])
    else $error("format detect flag not set");

  AST_FLAG2_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      event_in.format_change_flag |=> flags[2])
    else $error("format change flag not set");

  AST_FLAG1_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      event_in.mode_change_flag |=> flags[1])
    else $error("mode change flag not set");

  AST_FLAG0_SET:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      event_in.codec_link_event_flag |=> flags[0])
    else $error("codec link flag not set");

  AST_W1C_CLEARS:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_STATUS_ADDR) && (DATA_W'(event_in) == 8'h00)
      |=> (flags & $past(bus_req.wdata)) == 8'h00)
    else $error("write one did not clear flag");

  AST_W0_KEEPS:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_STATUS_ADDR) && bus_req.wdata == 8'h00 && DATA_W'(event_in) == 8'h00
      |=> $stable(flags))
    else $error("writing zero changed flags");

  AST_STICKY:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !wr_hit(bus_req, REG_STATUS_ADDR) |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without clear");

  AST_IRQ_GATED:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      1'b1 |=> irq == |($past(flags) & ~$past(mask)))
    else $error("interrupt output wrong");

  AST_STATUS_READ:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      bus_req.rd && bus_req.addr == REG_STATUS_ADDR |=> bus_rdata == $past(flags) ##1 (bus_rdata == 8'h00 || $past(bus_req.rd)))
    else $error("status read wrong");

  AST_BYPASS_GAIN:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      agc_bypass_enable |=> vga_gain == $past(agc_bypass_value) && acc == '0)
    else $error("bypass value not driven");

  AST_LOOP_HOLD:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable && !agc_feedback_gain_enable |=> $stable(vga_gain) && $stable(acc))
    else $error("loop moved while feedback gain off");

  AST_THRESHOLD:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable && agc_sample.valid && magnitude(agc_sample.err) <= ERR_W'(agc_error_threshold)
      |=> $stable(vga_gain) && $stable(acc))
    else $error("small error adjusted gain");

  AST_HYST_BAND:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable && loop_step && !step_down && !step_up
      |=> $stable(vga_gain) && acc == $past(next_acc))
    else $error("gain stepped inside hysteresis band");

  AST_STEP_DOWN:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable && loop_step && step_down && vga_gain != GAIN_MIN
      |=> vga_gain == $past(vga_gain) - 6'h01 && acc == '0)
    else $error("gain did not step down");

  AST_BOOST:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_AFE_ADDR) |=> front_end_boost_enable == $past(bus_req.wdata[FLD_BOOST_EN]))
    else $error("boost bit not taken");

  AST_DEC_SEL:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_DEC_ADDR) |=> decimation_source_select == $past(bus_req.wdata[FLD_DEC_SEL]))
    else $error("decimation select not taken");

  AST_STEP_UP:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable && loop_step && !step_down && step_up && vga_gain != GAIN_MAX
      |=> vga_gain == $past(vga_gain) + 6'h01 && acc == '0)
    else $error("gain did not step up");

  AST_GAIN_FLOOR:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable && loop_step && step_down && vga_gain == GAIN_MIN
      |=> vga_gain == GAIN_MIN && acc == '0)
    else $error("gain wrapped below minimum");

  AST_GAIN_CEIL:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable && loop_step && !step_down && step_up && vga_gain == GAIN_MAX
      |=> vga_gain == GAIN_MAX && acc == '0)
    else $error("gain wrapped above maximum");

  AST_STEP_ONE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable |=> vga_gain == $past(vga_gain) || vga_gain == $past(vga_gain) + 6'h01
                             || vga_gain == $past(vga_gain) - 6'h01)
    else $error("gain moved by more than one step");

  AST_NO_SAMPLE_HOLD:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !agc_bypass_enable && !agc_sample.valid |=> $stable(vga_gain) && $stable(acc))
    else $error("loop moved without a sample");

  AST_MASK_WRITE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_MASK_ADDR) |=> mask == $past(bus_req.wdata))
    else $error("mask write not taken");

  AST_MASK_HOLD:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !wr_hit(bus_req, REG_MASK_ADDR) |=> $stable(mask))
    else $error("mask changed without a write");

  AST_IRQ_RAISED:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      (flags & ~mask) != 8'h00 |=> irq)
    else $error("enabled flag did not raise interrupt");

  AST_FLAG_ONLY_EVENT:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      DATA_W'(event_in) == 8'h00 |=> (flags & ~$past(flags)) == 8'h00)
    else $error("flag set without an event");

  AST_CLEAR_EXACT:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_STATUS_ADDR)
      |=> flags == (($past(flags) & ~$past(bus_req.wdata)) | DATA_W'($past(event_in))))
    else $error("status write result wrong");

  AST_SET_WINS:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_STATUS_ADDR) && (DATA_W'(event_in) & bus_req.wdata) != 8'h00
      |=> (flags & DATA_W'($past(event_in))) == DATA_W'($past(event_in)))
    else $error("clear beat a same-cycle event");

  AST_HYST_A_WRITE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_HYST_A_ADDR) |=> agc_hysteresis_a == $past(bus_req.wdata[GAIN_W-1:0]))
    else $error("lower hysteresis write not taken");

  AST_THR_WRITE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_AGC_ADDR) |=> agc_error_threshold == $past(bus_req.wdata[GAIN_W-1:0]))
    else $error("error threshold write not taken");

  AST_FB_EN_WRITE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_AGC_ADDR) |=> agc_feedback_gain_enable == $past(bus_req.wdata[FLD_FB_GAIN_EN]))
    else $error("feedback gain enable not taken");

  AST_BYPASS_EN_WRITE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_AFE_ADDR) |=> agc_bypass_enable == $past(bus_req.wdata[FLD_BYPASS_EN]))
    else $error("bypass enable not taken");

  AST_BYPASS_VAL_WRITE:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_hit(bus_req, REG_AFE_ADDR) |=> agc_bypass_value == $past(bus_req.wdata[GAIN_W-1:0]))
    else $error("bypass value not taken");

  AST_CFG_HOLD:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !bus_req.wr |=> $stable(agc_hysteresis_a) && $stable(agc_hysteresis_b)
                      && $stable(agc_error_threshold) && $stable(agc_feedback_gain_enable))
    else $error("loop setting changed without a write");

  AST_AFE_HOLD:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !bus_req.wr |=> $stable(agc_bypass_enable) && $stable(agc_bypass_value)
                      && $stable(front_end_boost_enable) && $stable(decimation_source_select))
    else $error("front end setting changed without a write");

  AST_AFE_READ:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      bus_req.rd && bus_req.addr == REG_AFE_ADDR
      |=> bus_rdata == {$past(front_end_boost_enable), $past(agc_bypass_enable), $past(agc_bypass_value)})
    else $error("front end register read wrong");

  AST_RESET_STATE:
    assert property (@(posedge clk_sys)
      !rstn |=> flags == RST_FLAGS && mask == RST_MASK && !irq && bus_rdata == 8'h00)
    else $error("status or mask not at reset value");

  AST_RESET_CFG:
    assert property (@(posedge clk_sys)
      !rstn |=> agc_hysteresis_a == RST_HYST_A && agc_hysteresis_b == RST_HYST_B
                && agc_error_threshold == RST_ERR_THR && agc_bypass_value == RST_BYPASS_VAL
                && !agc_feedback_gain_enable && !agc_bypass_enable && !front_end_boost_enable
                && !decimation_source_select && vga_gain == RST_VGA_GAIN)
    else $error("control field not at reset value");

endmodule

`default_nettype wire

// ### shared/aia_pkg.sv
// Purpose: Constants and carrier types for the audio interrupt and IF AGC control block
// Assumes: 12-bit register addresses, 8-bit register data, one clock domain
// Notes:   Register map, field positions and values after reset

`default_nettype none

package aia_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int GAIN_W = 6;
  localparam int ERR_W  = 7;
  localparam int ACC_W  = 9;

  // Register addresses
  localparam logic [ADDR_W-1:0] REG_MASK_ADDR   = 12'h812;
  localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 12'h813;
  localparam logic [ADDR_W-1:0] REG_HYST_A_ADDR = 12'h814;
  localparam logic [ADDR_W-1:0] REG_HYST_B_ADDR = 12'h815;
  localparam logic [ADDR_W-1:0] REG_AGC_ADDR    = 12'h816;
  localparam logic [ADDR_W-1:0] REG_AFE_ADDR    = 12'h817;
  localparam logic [ADDR_W-1:0] REG_DEC_ADDR    = 12'h81b;

  // Field positions
  localparam int FLD_FB_GAIN_EN = 6;
  localparam int FLD_BOOST_EN   = 7;
  localparam int FLD_BYPASS_EN  = 6;
  localparam int FLD_DEC_SEL    = 0;

  // Values after reset, and the gain limits
  localparam logic [DATA_W-1:0] RST_FLAGS      = 8'h00;
  localparam logic [DATA_W-1:0] RST_MASK       = 8'hff;
  localparam logic [GAIN_W-1:0] RST_HYST_A     = 6'h05;
  localparam logic [GAIN_W-1:0] RST_HYST_B     = 6'h09;
  localparam logic [GAIN_W-1:0] RST_ERR_THR    = 6'h0e;
  localparam logic [GAIN_W-1:0] RST_BYPASS_VAL = 6'h20;
  localparam logic [GAIN_W-1:0] RST_VGA_GAIN   = 6'h20;
  localparam logic [GAIN_W-1:0] GAIN_MAX       = 6'h3f;
  localparam logic [GAIN_W-1:0] GAIN_MIN       = 6'h00;

  typedef struct packed {
    logic radio_data_ready_flag;
    logic high_bit_error_flag;
    logic digital_sound_lock_lost_flag;
    logic if_signal_lost_flag;
    logic format_detect_done_flag;
    logic format_change_flag;
    logic mode_change_flag;
    logic codec_link_event_flag;
  } aia_event_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } aia_bus_req_type;

  typedef struct packed {
    logic             valid;
    logic [ERR_W-1:0] err;
  } aia_agc_sample_type;

endpackage

`default_nettype wire

// ### dv/aia_afe_model.sv
// Purpose: Far-side AGC error source standing in for the IF level detector
// Assumes: One error sample per cycle of send, synchronous to clk_sys
// Notes:   Between samples the error bus toggles, so stale data never passes for a sample
`timescale 1ns/1ps
`default_nettype none
module aia_afe_model (
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire logic                        send,
  input  wire logic [aia_pkg::ERR_W-1:0]   err_code,
  output var  aia_pkg::aia_agc_sample_type agc_sample
);
  import aia_pkg::*;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      agc_sample <= '0;
    end else if (send) begin
      agc_sample.valid <= 1'b1;
      agc_sample.err   <= err_code;
    end else begin
      agc_sample.valid <= 1'b0;
      agc_sample.err   <= ~agc_sample.err;
    end
  end
endmodule
`default_nettype wire

// ### dv/audio_irq_status_and_agc_control_tb_top.sv
// Purpose: Self-checking bench for the interrupt flags and IF AGC controls
// Assumes: Plain register port, 40 MHz clock, fixed random seed
// Notes:   Each AGC case re-enters bypass first so the loop accumulator starts from zero
`timescale 1ns/1ps
`default_nettype none
module audio_irq_status_and_agc_control_tb_top;
  import aia_pkg::*;
  logic               clk_sys, rstn, send, boost, dec_sel, irq;
  aia_bus_req_type    bus_req;
  aia_event_type      event_in;
  aia_agc_sample_type agc_sample;
  logic [DATA_W-1:0]  bus_rdata, d;
  logic [GAIN_W-1:0]  vga_gain, thr, ha, hb, bv;
  logic [ERR_W-1:0]   err_code, e;
  logic               en, bst;
  int                 failures, comparisons;
  localparam logic [11:0] ADDRS [8] = '{REG_MASK_ADDR, REG_STATUS_ADDR, REG_HYST_A_ADDR, REG_HYST_B_ADDR,
                                        REG_AGC_ADDR, REG_AFE_ADDR, REG_DEC_ADDR, 12'h818};
  localparam logic [7:0]  RSTV [8]  = '{8'hff, 8'h00, 8'h05, 8'h09, 8'h0e, 8'h20, 8'h00, 8'h00};
  localparam logic [7:0]  WMSK [8]  = '{8'hff, 8'h00, 8'h3f, 8'h3f, 8'h7f, 8'hff, 8'h01, 8'h00};

  aia_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata), .event_in(event_in),
                .agc_sample(agc_sample), .vga_gain(vga_gain), .front_end_boost_enable(boost),
                .decimation_source_select(dec_sel), .irq(irq));
  aia_afe_model afe (.clk_sys(clk_sys), .rstn(rstn), .send(send), .err_code(err_code), .agc_sample(agc_sample));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_sys);
    event_in <= v;
    @(posedge clk_sys);
    event_in <= '0;
    settle;
  endtask
  // Loop step for one sample taken with the accumulator at zero
  function automatic logic [5:0] exp_gain(input logic [5:0] g, input logic [6:0] ev, input logic on,
                                          input logic [5:0] t, input logic [5:0] lo, input logic [5:0] up);
    int v;
    v = int'($signed(ev));
    if (!on || (v < 0 ? -v : v) <= int'(t)) return g;
    if (v > int'(up)) return (g == GAIN_MIN) ? g : g - 6'h01;
    if (v < -int'(lo)) return (g == GAIN_MAX) ? g : g + 6'h01;
    return g;
  endfunction
  task automatic wrap_up;
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    wrap_up;
  end
  initial begin
    rstn = 1'b0;
    bus_req = '0;
    event_in = '0;
    send = 1'b0;
    err_code = '0;
    void'($urandom(52068));
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    settle;
    chk({2'b00, vga_gain}, 8'h20);
    chk({6'h00, boost, dec_sel}, 8'h00);
    for (int k = 0; k < 8; k++) rchk(ADDRS[k], RSTV[k]);
    for (int n = 0; n < 3; n++) begin
      for (int k = 0; k < 8; k++) begin
        d = 8'($urandom);
        wr(ADDRS[k], d);
        rchk(ADDRS[k], d & WMSK[k]);
        if (k == 5) chk({7'h00, boost}, {7'h00, d[7]});
        if (k == 6) chk({7'h00, dec_sel}, {7'h00, d[0]});
      end
    end
    for (int i = 0; i < 8; i++) begin
      wr(REG_MASK_ADDR, 8'h01 << i);
      pulse(8'h01 << i);
      chk({7'h00, irq}, 8'h00);
      rchk(REG_STATUS_ADDR, 8'h01 << i);
      wr(REG_STATUS_ADDR, 8'h00);
      rchk(REG_STATUS_ADDR, 8'h01 << i);
      wr(REG_STATUS_ADDR, ~(8'h01 << i));
      rchk(REG_STATUS_ADDR, 8'h01 << i);
      wr(REG_MASK_ADDR, ~(8'h01 << i));
      settle;
      chk({7'h00, irq}, 8'h01);
      @(posedge clk_sys);
      bus_req <= '{addr: REG_STATUS_ADDR, wdata: 8'h01 << i, wr: 1'b1, rd: 1'b0};
      event_in <= 8'h01 << i;
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
      event_in <= '0;
      rchk(REG_STATUS_ADDR, 8'h01 << i);
      wr(REG_STATUS_ADDR, 8'h01 << i);
      rchk(REG_STATUS_ADDR, 8'h00);
      chk({7'h00, irq}, 8'h00);
    end
    for (int n = 0; n < 40; n++) begin
      thr = 6'($urandom_range(0, 24));
      ha = 6'($urandom);
      hb = 6'($urandom);
      bv = (n < 2) ? {6{n[0]}} : 6'($urandom);
      en = (n % 5) != 4;
      bst = 1'($urandom);
      e = 7'($urandom);
      wr(REG_HYST_A_ADDR, {2'b00, ha});
      wr(REG_HYST_B_ADDR, {2'b00, hb});
      wr(REG_AGC_ADDR, {1'b0, en, thr});
      wr(REG_AFE_ADDR, {bst, 1'b1, bv});
      settle;
      chk({2'b00, vga_gain}, {2'b00, bv});
      chk({7'h00, boost}, {7'h00, bst});
      wr(REG_AFE_ADDR, {bst, 1'b0, bv});
      @(posedge clk_sys);
      send <= 1'b1;
      err_code <= e;
      @(posedge clk_sys);
      send <= 1'b0;
      settle;
      chk({2'b00, vga_gain}, {2'b00, exp_gain(bv, e, en, thr, ha, hb)});
    end
    // Mid-run reset with flags pending: everything must return to its reset value
    pulse(8'h81);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    settle;
    chk({6'h00, irq, boost}, 8'h00);
    chk({2'b00, vga_gain}, 8'h20);
    for (int k = 0; k < 8; k++) rchk(ADDRS[k], RSTV[k]);
    wrap_up;
  end
endmodule
`default_nettype wire
